// [design/wtcr_regs.v]
// serial register bank for wake, timer and transceiver mode control
`timescale 1ns/1ns
`default_nettype none
`include "wtcr_defs.vh"
module wtcr_regs (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        softReset,
  // serial link
  input  wire        spiCsN,
  input  wire        spiSck,
  input  wire        spiMosi,
  output reg         spiMiso,
  // device mode
  input  wire        devNormal,
  input  wire        devStop,
  input  wire        devSleep,
  // device side events
  input  wire        hwStopWdUpdate,
  input  wire        hwStopWdValue,
  input  wire        wdFailEvent,
  input  wire        wdTriggerOk,
  input  wire [7:0]  supplyEvent,
  input  wire [7:0]  thermalEvent,
  input  wire [7:0]  deviceEvent,
  // control outputs
  output reg  [1:0]  secondLinMode,
  output reg         timerWakeEnable,
  output reg         stopWatchdogDisable,
  output reg         wakePinEnable,
  output reg  [1:0]  wakePinPullSelect,
  output reg  [2:0]  timerPeriodCode,
  output reg  [10:0] timerPeriodMs,
  output reg         timerPeriodReserved,
  output reg         commandFail,
  output reg  [1:0]  watchdogFailureCounter
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function isStatusAddr;
    input [6:0] addr;
    begin
      isStatusAddr = (addr == `WTCR_ADDR_SUPPLY) || (addr == `WTCR_ADDR_THERMAL) ||
                     (addr == `WTCR_ADDR_DEVICE);
    end
  endfunction

  function [10:0] periodMs;
    input [2:0] code;
    begin
      case (code)
        3'h0: periodMs = `WTCR_PER_0;
        3'h1: periodMs = `WTCR_PER_1;
        3'h2: periodMs = `WTCR_PER_2;
        3'h3: periodMs = `WTCR_PER_3;
        3'h4: periodMs = `WTCR_PER_4;
        3'h5: periodMs = `WTCR_PER_5;
        3'h6: periodMs = `WTCR_PER_6;
        default: periodMs = `WTCR_PER_RSVD;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [7:0]  linCtrl;
  reg  [7:0]  wakeControlOne;
  reg  [7:0]  wakeSourceControl;
  reg  [7:0]  wakePinPullControl;
  reg  [7:0]  periodicTimerControl;
  reg  [7:0]  hostScratchValue;
  reg  [15:0] rxShift;
  reg  [4:0]  bitCount;
  reg  [7:0]  txByte;
  reg  [7:0]  readLatch;
  reg         prevSck;
  reg         prevCs;
  wire [23:0] statusBus;
  wire [7:0]  supplyStatus;
  wire [7:0]  thermalStatus;
  wire [7:0]  deviceStatus;

  // ----------------------------------------------------------------
  // link edges
  // ----------------------------------------------------------------
  wire sckRise = spiSck & ~prevSck & ~spiCsN;
  wire sckFall = ~spiSck & prevSck & ~spiCsN;
  wire csFall  = prevCs & ~spiCsN;
  wire csRise  = ~prevCs & spiCsN;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prevSck <= 1'b0;
      prevCs  <= 1'b1;
    end else begin
      prevSck <= spiSck;
      prevCs  <= spiCsN;
    end
  end

  // ----------------------------------------------------------------
  // frame commit decode
  // ----------------------------------------------------------------
  wire       frameOk    = csRise && (bitCount == `WTCR_FRAME_BITS);
  wire       frameBad   = csRise && (bitCount != `WTCR_FRAME_BITS);
  wire [6:0] frameAddr  = rxShift[`WTCR_ADDR_MSB:0];
  wire       frameWrite = rxShift[`WTCR_MODE_BIT];
  wire [7:0] frameData  = rxShift[15:8];
  wire       ctrlWrite  = frameOk && frameWrite && !isStatusAddr(frameAddr);
  // status frames never look at the data byte
  wire       statClear  = frameOk && frameWrite && isStatusAddr(frameAddr);
  wire       scratchOk  = devNormal | devStop;

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  reg [7:0] readValue;
  always @* begin
    case (frameAddr)
      `WTCR_ADDR_LINCTRL:  readValue = linCtrl;
      `WTCR_ADDR_WAKEONE:  readValue = wakeControlOne;
      `WTCR_ADDR_WAKESRC:  readValue = wakeSourceControl;
      `WTCR_ADDR_WAKEPULL: readValue = wakePinPullControl;
      `WTCR_ADDR_TIMER:    readValue = periodicTimerControl;
      `WTCR_ADDR_SCRATCH:  readValue = hostScratchValue;
      `WTCR_ADDR_SUPPLY:   readValue = supplyStatus;
      `WTCR_ADDR_THERMAL:  readValue = thermalStatus;
      `WTCR_ADDR_DEVICE:   readValue = deviceStatus;
      default:             readValue = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // receive and transmit shifting, least significant bit first
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxShift   <= 16'h0000;
      bitCount  <= 5'h00;
      txByte    <= 8'h00;
      readLatch <= 8'h00;
      spiMiso   <= 1'b0;
    end else if (csFall) begin
      rxShift   <= 16'h0000;
      bitCount  <= 5'h00;
      txByte    <= deviceStatus;
      spiMiso   <= deviceStatus[0];
    end else if (sckRise) begin
      if (bitCount < `WTCR_FRAME_BITS) begin
        rxShift[bitCount[3:0]] <= spiMosi;
      end
      if (bitCount != `WTCR_BIT_SAT) begin
        bitCount <= bitCount + 5'h01;
      end
    end else if (sckFall) begin
      if (bitCount == 5'h08) begin
        readLatch <= readValue;
        spiMiso   <= readValue[0];
      end else if (bitCount > 5'h08 && bitCount < `WTCR_FRAME_BITS) begin
        spiMiso <= readLatch[bitCount[2:0]];
      end else if (bitCount < 5'h08) begin
        spiMiso <= txByte[bitCount[2:0]];
      end else begin
        spiMiso <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers, loaded with their reset values by power-on or soft reset
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      linCtrl              <= `WTCR_RST_LINCTRL;
      wakeControlOne       <= `WTCR_RST_WAKEONE;
      wakeSourceControl    <= `WTCR_RST_WAKESRC;
      wakePinPullControl   <= `WTCR_RST_WAKEPULL;
      periodicTimerControl <= `WTCR_RST_TIMER;
    end else if (softReset) begin
      linCtrl              <= `WTCR_RST_LINCTRL;
      wakeControlOne       <= `WTCR_RST_WAKEONE;
      wakeSourceControl    <= `WTCR_RST_WAKESRC;
      wakePinPullControl   <= `WTCR_RST_WAKEPULL;
      periodicTimerControl <= `WTCR_RST_TIMER;
    end else begin
      if (ctrlWrite && frameAddr == `WTCR_ADDR_LINCTRL) begin
        linCtrl <= frameData & `WTCR_MASK_LINCTRL;
      end
      if (hwStopWdUpdate) begin
        wakeControlOne[`WTCR_STOP_WD_BIT] <= hwStopWdValue;
      end else if (ctrlWrite && frameAddr == `WTCR_ADDR_WAKEONE) begin
        wakeControlOne <= frameData & `WTCR_MASK_WAKEONE;
      end
      if (ctrlWrite && frameAddr == `WTCR_ADDR_WAKESRC) begin
        wakeSourceControl <= frameData & `WTCR_MASK_WAKESRC;
      end
      if (ctrlWrite && frameAddr == `WTCR_ADDR_WAKEPULL) begin
        wakePinPullControl <= frameData & `WTCR_MASK_WAKEPULL;
      end
      if (ctrlWrite && frameAddr == `WTCR_ADDR_TIMER) begin
        periodicTimerControl <= frameData & `WTCR_MASK_TIMER;
      end
    end
  end

  // ----------------------------------------------------------------
  // scratch byte: only power-on clears it, only the read multiplexer reads it
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hostScratchValue <= `WTCR_RST_SCRATCH;
    end else if (ctrlWrite && scratchOk && frameAddr == `WTCR_ADDR_SCRATCH) begin
      hostScratchValue <= frameData;
    end
  end

  // ----------------------------------------------------------------
  // status bytes
  // ----------------------------------------------------------------
  wire [23:0] statusSet;
  wire [2:0]  statusClr;
  assign statusSet = {deviceEvent & `WTCR_CLR_DEVICE | {6'h00, frameBad, 1'b0}, thermalEvent, supplyEvent};
  assign statusClr[0] = statClear && frameAddr == `WTCR_ADDR_SUPPLY;
  assign statusClr[1] = statClear && frameAddr == `WTCR_ADDR_THERMAL;
  assign statusClr[2] = statClear && frameAddr == `WTCR_ADDR_DEVICE;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gStatus
      localparam [7:0] MASK = (gi == 0) ? `WTCR_CLR_SUPPLY :
                              (gi == 1) ? `WTCR_CLR_THERMAL : `WTCR_CLR_DEVICE;
      wtcr_status_byte #(
        .CLR_MASK (MASK)
      ) uByte (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .softReset (softReset),
        .setIn     (statusSet[gi*8 +: 8]),
        .clearByte (statusClr[gi]),
        .status    (statusBus[gi*8 +: 8])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // watchdog failure counter, updated only by the device
  // ----------------------------------------------------------------
  reg [1:0] wdFailCount;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdFailCount <= 2'h0;
    end else if (softReset) begin
      wdFailCount <= 2'h0;
    end else if (wdFailEvent) begin
      if (wdFailCount != `WTCR_WATCHDOG_FAILURE_COUNTER_MAX) begin
        wdFailCount <= wdFailCount + 2'h1;
      end
    end else if (wdTriggerOk) begin
      wdFailCount <= 2'h0;
    end
  end

  assign supplyStatus  = statusBus[7:0];
  assign thermalStatus = statusBus[15:8];
  assign deviceStatus  = {statusBus[23:20], wdFailCount, statusBus[17:16]};

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  wire lowPower = devStop | devSleep;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secondLinMode          <= 2'h0;
      timerWakeEnable        <= 1'b0;
      stopWatchdogDisable    <= 1'b0;
      wakePinEnable          <= 1'b1;
      wakePinPullSelect      <= 2'h0;
      timerPeriodCode        <= 3'h0;
      timerPeriodMs          <= `WTCR_PER_0;
      timerPeriodReserved    <= 1'b0;
      commandFail            <= 1'b0;
      watchdogFailureCounter <= 2'h0;
    end else begin
      // stored field is kept, only the applied mode drops to wake
      if (lowPower && linCtrl[1:0] == `WTCR_LIN_NORMAL) begin
        secondLinMode <= `WTCR_LIN_WAKE;
      end else begin
        secondLinMode <= linCtrl[1:0];
      end
      timerWakeEnable        <= wakeControlOne[`WTCR_TIMER_WAKE_BIT];
      stopWatchdogDisable    <= wakeControlOne[`WTCR_STOP_WD_BIT];
      wakePinEnable          <= wakeSourceControl[`WTCR_WAKE_EN_BIT];
      wakePinPullSelect      <= wakePinPullControl[1:0];
      timerPeriodCode        <= periodicTimerControl[2:0];
      timerPeriodMs          <= periodMs(periodicTimerControl[2:0]);
      timerPeriodReserved    <= (periodicTimerControl[2:0] == 3'h7);
      commandFail            <= deviceStatus[1];
      watchdogFailureCounter <= wdFailCount;
    end
  end

endmodule // wtcr_regs
`default_nettype wire

// [design/wtcr_defs.vh]
// constants for the wake and timer control register block
`ifndef WTCR_DEFS_VH
`define WTCR_DEFS_VH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define WTCR_FRAME_BITS     5'h10
`define WTCR_ADDR_MSB       6
`define WTCR_MODE_BIT       7
`define WTCR_BIT_SAT        5'h11

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WTCR_ADDR_LINCTRL   7'h05
`define WTCR_ADDR_WAKEONE   7'h06
`define WTCR_ADDR_WAKESRC   7'h07
`define WTCR_ADDR_WAKEPULL  7'h08
`define WTCR_ADDR_TIMER     7'h0C
`define WTCR_ADDR_SCRATCH   7'h1E
`define WTCR_ADDR_SUPPLY    7'h41
`define WTCR_ADDR_THERMAL   7'h42
`define WTCR_ADDR_DEVICE    7'h43
`define WTCR_STATUS_BASE    7'h40

// ----------------------------------------------------------------
// field positions and writable masks
// ----------------------------------------------------------------
`define WTCR_TIMER_WAKE_BIT 6
`define WTCR_STOP_WD_BIT    2
`define WTCR_WAKE_EN_BIT    0
`define WTCR_MASK_LINCTRL   8'h03
`define WTCR_MASK_WAKEONE   8'h44
`define WTCR_MASK_WAKESRC   8'h01
`define WTCR_MASK_WAKEPULL  8'h03
`define WTCR_MASK_TIMER     8'h07
`define WTCR_CLR_SUPPLY     8'hFD
`define WTCR_CLR_THERMAL    8'h07
`define WTCR_CLR_DEVICE     8'hF3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WTCR_RST_LINCTRL    8'h00
`define WTCR_RST_WAKEONE    8'h00
`define WTCR_RST_WAKESRC    8'h01
`define WTCR_RST_WAKEPULL   8'h00
`define WTCR_RST_TIMER      8'h00
`define WTCR_RST_SCRATCH    8'h00

// ----------------------------------------------------------------
// mode codes and timer periods in ms
// ----------------------------------------------------------------
`define WTCR_LIN_NORMAL     2'h3
`define WTCR_LIN_WAKE       2'h1
`define WTCR_WATCHDOG_FAILURE_COUNTER_MAX    2'h2
`define WTCR_PER_0          11'h00A
`define WTCR_PER_1          11'h014
`define WTCR_PER_2          11'h032
`define WTCR_PER_3          11'h064
`define WTCR_PER_4          11'h0C8
`define WTCR_PER_5          11'h3E8
`define WTCR_PER_6          11'h7D0
`define WTCR_PER_RSVD       11'h000

`endif

// [design/wtcr_status_byte.v]
// one status byte with sticky clearable bits
`timescale 1ns/1ns
`default_nettype none
module wtcr_status_byte #(
  parameter [7:0] CLR_MASK = 8'hFF
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       softReset,
  // events and host clear
  input  wire [7:0] setIn,
  input  wire       clearByte,
  // state
  output reg  [7:0] status
);

  wire [7:0] next_status;

  // set wins over a clear in the same cycle
  assign next_status = clearByte ? (setIn & CLR_MASK) : ((status | setIn) & CLR_MASK);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= 8'h00;
    end else if (softReset) begin
      status <= 8'h00;
    end else begin
      status <= next_status;
    end
  end

endmodule // wtcr_status_byte
`default_nettype wire

// [verification/wtcr_regs_checker.sv]
// assertion checker for the wake and timer control register bank
`timescale 1ns/1ns
`default_nettype none
module wtcr_regs_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        softReset,
  // link, mode and events
  input wire logic        spiCsN,
  input wire logic        spiSck,
  input wire logic        devStop,
  input wire logic        wdFailEvent,
  input wire logic        wdTriggerOk,
  // outputs
  input wire logic [1:0]  secondLinMode,
  input wire logic        timerWakeEnable,
  input wire logic        wakePinEnable,
  input wire logic [2:0]  timerPeriodCode,
  input wire logic [10:0] timerPeriodMs,
  input wire logic        timerPeriodReserved,
  input wire logic        commandFail,
  input wire logic [1:0]  watchdogFailureCounter
);
  logic       csPrev;
  logic       sckPrev;
  logic [4:0] sckCount;
  logic [2:0] quietCount;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // frame clock count and quiet time since the last frame
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      csPrev     <= 1'b1;
      sckPrev    <= 1'b0;
      sckCount   <= 5'h00;
      quietCount <= 3'h0;
    end else begin
      csPrev  <= spiCsN;
      sckPrev <= spiSck;
      if (spiCsN && csPrev)
        sckCount <= 5'h00;
      else if (!spiCsN && spiSck && !sckPrev && sckCount != 5'h1F)
        sckCount <= sckCount + 5'h01;
      if (softReset || !spiCsN)
        quietCount <= 3'h0;
      else if (quietCount != 3'h7)
        quietCount <= quietCount + 3'h1;
    end
  end

  sequence sSoftPulse;
    softReset ##1 !softReset;
  endsequence
  sequence sGoodTrigger;
    wdTriggerOk && !wdFailEvent && !softReset ##1 !wdFailEvent [*2];
  endsequence

  a_reset_state: assert property (disable iff (1'b0) !reset_n |-> wakePinEnable && !timerWakeEnable
    && secondLinMode == 2'h0 && timerPeriodMs == 11'h00A) else $error("outputs wrong in reset");
  a_soft_restore: assert property (sSoftPulse |-> ##1 wakePinEnable && !timerWakeEnable
    && timerPeriodCode == 3'h0) else $error("soft reset did not restore controls");
  a_lin_demote: assert property (devStop [*2] |-> secondLinMode != 2'h3)
    else $error("normal transceiver mode applied in stop");
  a_period_reserved: assert property (timerPeriodCode == 3'h7 |-> timerPeriodReserved
    && timerPeriodMs == 11'h000) else $error("reserved period code not flagged");
  a_wd_cleared: assert property (sGoodTrigger |-> watchdogFailureCounter == 2'h0)
    else $error("failure counter kept after good trigger");
  a_wd_saturate: assert property (watchdogFailureCounter != 2'h3)
    else $error("failure counter reached three");
  a_fail_on_bad: assert property (spiCsN && !csPrev && sckCount != 5'h10 |-> ##[1:5] commandFail)
    else $error("bad frame not flagged");
  a_fail_sticky: assert property (commandFail && quietCount >= 3'h6 |=> commandFail)
    else $error("command failure flag dropped by itself");
endmodule // wtcr_regs_checker

bind wtcr_regs wtcr_regs_checker chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .softReset(softReset), .spiCsN(spiCsN), .spiSck(spiSck),
  .devStop(devStop), .wdFailEvent(wdFailEvent), .wdTriggerOk(wdTriggerOk), .secondLinMode(secondLinMode),
  .timerWakeEnable(timerWakeEnable), .wakePinEnable(wakePinEnable), .timerPeriodCode(timerPeriodCode),
  .timerPeriodMs(timerPeriodMs), .timerPeriodReserved(timerPeriodReserved), .commandFail(commandFail),
  .watchdogFailureCounter(watchdogFailureCounter)
);
`default_nettype wire

// [verification/wtcr_host_model.sv]
// host model acting as serial master for the register bank
`timescale 1ns/1ns
`default_nettype none
module wtcr_host_model (
  // clock
  input  wire logic sys_clk,
  // serial link
  output var logic  spiCsN,
  output var logic  spiSck,
  output var logic  spiMosi,
  input  wire logic spiMiso
);
  initial begin
    spiCsN  = 1'b1;
    spiSck  = 1'b0;
    spiMosi = 1'b0;
  end

  // lsb first; a legal frame has sixteen clocks
  task automatic xfer(input logic [15:0] frame, input int clocks, output logic [15:0] resp);
    resp = 16'h0000;
    @(posedge sys_clk);
    spiCsN  <= 1'b0;
    spiMosi <= frame[0];
    for (int i = 0; i < clocks; i++) begin
      repeat (3) @(posedge sys_clk);
      resp[i % 16] = spiMiso;
      spiSck <= 1'b1;
      repeat (2) @(posedge sys_clk);
      spiSck  <= 1'b0;
      spiMosi <= frame[(i + 1) % 16];
    end
    repeat (3) @(posedge sys_clk);
    spiCsN  <= 1'b1;
    spiMosi <= ~spiMosi;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule // wtcr_host_model
`default_nettype wire

// [verification/wtcr_regs_tb.sv]
// self-checking bench for the wake and timer control register bank
`timescale 1ns/1ns
`default_nettype none
module wtcr_regs_tb;
  localparam logic [6:0]  ADDRS [6] = '{7'h05, 7'h06, 7'h07, 7'h08, 7'h0C, 7'h1E};
  localparam logic [7:0]  RSTV [6]  = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [10:0] MS [8]    = '{11'h00A, 11'h014, 11'h032, 11'h064, 11'h0C8, 11'h3E8, 11'h7D0, 11'h000};
  logic sys_clk = 1'b0, reset_n = 1'b1, softReset = 1'b0, devNormal = 1'b1, devStop = 1'b0, devSleep = 1'b0;
  logic hwStopWdUpdate = 1'b0, hwStopWdValue = 1'b0, wdFailEvent = 1'b0, wdTriggerOk = 1'b0;
  logic [7:0] supplyEvent = 8'h00, thermalEvent = 8'h00, deviceEvent = 8'h00;
  wire logic spiCsN, spiSck, spiMosi, spiMiso, timerWakeEnable, stopWatchdogDisable, wakePinEnable;
  wire logic timerPeriodReserved, commandFail;
  wire logic [1:0] secondLinMode, wakePinPullSelect, watchdogFailureCounter;
  wire logic [2:0] timerPeriodCode;
  wire logic [10:0] timerPeriodMs;
  int failCount = 0, compares = 0, cycles = 0;

  always #20 sys_clk = ~sys_clk;

  wtcr_host_model host_u (.sys_clk(sys_clk), .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso));
  wtcr_regs dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .softReset(softReset), .spiCsN(spiCsN), .spiSck(spiSck),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .devNormal(devNormal), .devStop(devStop), .devSleep(devSleep),
    .hwStopWdUpdate(hwStopWdUpdate), .hwStopWdValue(hwStopWdValue), .wdFailEvent(wdFailEvent),
    .wdTriggerOk(wdTriggerOk), .supplyEvent(supplyEvent), .thermalEvent(thermalEvent), .deviceEvent(deviceEvent),
    .secondLinMode(secondLinMode), .timerWakeEnable(timerWakeEnable), .stopWatchdogDisable(stopWatchdogDisable),
    .wakePinEnable(wakePinEnable), .wakePinPullSelect(wakePinPullSelect), .timerPeriodCode(timerPeriodCode),
    .timerPeriodMs(timerPeriodMs), .timerPeriodReserved(timerPeriodReserved), .commandFail(commandFail),
    .watchdogFailureCounter(watchdogFailureCounter));

  function automatic logic [7:0] mask(input logic [6:0] addr);
    case (addr)
      7'h05, 7'h08: mask = 8'h03;
      7'h06: mask = 8'h44;
      7'h07: mask = 8'h01;
      7'h0C: mask = 8'h07;
      7'h1E: mask = 8'hFF;
      default: mask = 8'h00;
    endcase
  endfunction

  task automatic summarize();
    if (failCount == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tally(input logic bad, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (bad) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkRd(input logic [7:0] got, input logic [7:0] exp);
    tally(got !== exp, {8'h00, got}, {8'h00, exp});
  endtask
  task automatic chkOut(input logic [11:0] got, input logic [11:0] exp);
    tally(got !== exp, {4'h0, got}, {4'h0, exp});
  endtask
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [15:0] resp;
    host_u.xfer({data, 1'b1, addr}, 16, resp);
  endtask
  task automatic rd(input logic [6:0] addr, output logic [7:0] data);
    logic [15:0] resp;
    host_u.xfer({8'hA5, 1'b0, addr}, 16, resp);
    data = resp[15:8];
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      summarize();
    end
  end

  initial begin
    logic [7:0] d;
    logic [6:0] a;
    logic [15:0] r;
    void'($urandom(2829));
    reset_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(ADDRS[k], d);
      chkRd(d, RSTV[k]);
    end
    repeat (24) begin
      a = ADDRS[$urandom_range(5)];
      d = 8'($urandom);
      wr(a, d);
      case (a)
        7'h05: chkOut(secondLinMode, d[1:0]);
        7'h06: chkOut({stopWatchdogDisable, timerWakeEnable}, {d[2], d[6]});
        7'h07: chkOut(wakePinEnable, d[0]);
        7'h08: chkOut(wakePinPullSelect, d[1:0]);
        7'h0C: chkOut(timerPeriodCode, d[2:0]);
        default: chkOut(timerPeriodMs, MS[timerPeriodCode]);
      endcase
      rd(a, r[7:0]);
      chkRd(r[7:0], d & mask(a));
    end
    wr(7'h20, 8'hFF);
    rd(7'h20, d);
    chkRd(d, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(7'h0C, 8'(c));
      chkOut({timerPeriodReserved, timerPeriodMs}, {c == 7, MS[c]});
    end
    for (int m = 0; m < 8; m++) begin
      wr(7'h05, 8'(m[1:0]));
      devNormal <= 1'b0;
      devStop <= m[2];
      devSleep <= !m[2];
      repeat (4) @(posedge sys_clk);
      chkOut(secondLinMode, (m[1:0] == 2'h3) ? 2'h1 : m[1:0]);
      {devNormal, devStop, devSleep} <= 3'b100;
      repeat (4) @(posedge sys_clk);
      chkOut(secondLinMode, m[1:0]);
    end
    wr(7'h1E, 8'h5A);
    softReset <= 1'b1;
    @(posedge sys_clk);
    softReset <= 1'b0;
    rd(7'h1E, d);
    chkRd(d, 8'h5A);
    rd(7'h07, d);
    chkRd(d, 8'h01);
    devNormal <= 1'b0;
    wr(7'h1E, 8'hC3);
    rd(7'h1E, d);
    chkRd(d, 8'h5A);
    devStop <= 1'b1;
    wr(7'h1E, 8'hC3);
    rd(7'h1E, d);
    chkRd(d, 8'hC3);
    {devNormal, devStop} <= 2'b10;
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(7'h1E, d);
    chkRd(d, 8'h00);
    {supplyEvent, thermalEvent, deviceEvent} <= {8'hFF, 8'hFF, 8'h10};
    @(posedge sys_clk);
    {supplyEvent, thermalEvent, deviceEvent} <= 24'h000000;
    host_u.xfer({8'hFF, 1'b0, 7'h43}, 16, r);
    chkRd(r[7:0], 8'h10);
    rd(7'h43, d);
    chkRd(d, 8'h10);
    rd(7'h41, d);
    chkRd(d, 8'hFD);
    rd(7'h42, d);
    chkRd(d, 8'h07);
    wr(7'h42, 8'h00);
    rd(7'h42, d);
    chkRd(d, 8'h00);
    repeat (3) begin
      wdFailEvent <= 1'b1;
      @(posedge sys_clk);
      wdFailEvent <= 1'b0;
      @(posedge sys_clk);
    end
    wr(7'h43, 8'hFF);
    rd(7'h43, d);
    chkRd(d, 8'h08);
    wdTriggerOk <= 1'b1;
    @(posedge sys_clk);
    wdTriggerOk <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chkOut(watchdogFailureCounter, 2'h0);
    {hwStopWdUpdate, hwStopWdValue} <= 2'b11;
    @(posedge sys_clk);
    hwStopWdUpdate <= 1'b0;
    rd(7'h06, d);
    chkRd(d, 8'h04);
    for (int n = 15; n <= 17; n += 2) begin
      host_u.xfer({8'h00, 1'b1, 7'h07}, n, r);
      chkOut(commandFail, 1'b1);
      rd(7'h07, d);
      chkRd(d, 8'h01);
      wr(7'h43, 8'h00);
      chkOut(commandFail, 1'b0);
    end
    summarize();
  end
endmodule // wtcr_regs_tb
`default_nettype wire
